// *** dv/mns_chk.sv ***
/* Port checker for the next-address sequencer.
   Assumes it is bound to mns_seq; outputs lag inputs by three edges. */
`timescale 1ns/1ns
// ========
// Checker
module mns_chk (
	input wire        clk,
	input wire        rst_n,
	input wire [3:0]  instr,
	input wire [11:0] direct_in,
	input wire        condition_code_n,
	input wire        condition_enable_n,
	input wire        carry_in,
	input wire [11:0] next_addr_r,
	input wire        vector_enable_n
);
	reg  [15:0] op_r = 16'heeee;
	reg  [3:0]  ci_r = 4'h0;
	reg  [2:0]  ps_r = 3'h0;
	reg  [11:0] yp_r = 12'h000;
	wire [3:0]  op3 = op_r[11:8];
	wire [11:0] nx = yp_r + {11'h0, ci_r[3]};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Delay lines keep the cause aligned with the registered answer
	always @(posedge clk) begin
		op_r <= {op_r[11:0], instr};
		ci_r <= {ci_r[2:0], carry_in};
		ps_r <= {ps_r[1:0], condition_enable_n | ~condition_code_n};
		yp_r <= next_addr_r;
	end
	vector_enable_n_a: assert property (vector_enable_n == (op3 != 4'h6))
		else $error("vector enable wrong");
	seq_a: assert property (op3 inside {4'h4, 4'hc, 4'he} |-> next_addr_r == nx)
		else $error("sequential address wrong");
	dsel_a: assert property (op3 inside {4'h5, 4'h6, 4'h7, 4'hb} && ps_r[2] |->
		next_addr_r == $past(direct_in, 3)) else $error("direct branch wrong");
	fail_pc_a: assert property (op3 inside {4'h6, 4'ha, 4'hb} && !ps_r[2] |-> next_addr_r == nx)
		else $error("failed test did not continue");
	loop_exit_a: assert property (op3 == 4'hd && ps_r[2] |-> next_addr_r == nx)
		else $error("loop exit wrong");
	rpt_go_a: assert property (op_r[15:12] == 4'hc && op3 == 4'h9 && $past(direct_in, 4) != 12'h000 |->
		next_addr_r == $past(direct_in, 3)) else $error("repeat branch wrong");
	rpt_end_a: assert property (op_r[15:12] == 4'hc && op3 == 4'h9 && $past(direct_in, 4) == 12'h000 |->
		next_addr_r == nx) else $error("repeat exit wrong");
	stack_ret_a: assert property (op_r[15:12] == 4'h4 && (op3 == 4'ha && ps_r[2] || op3 == 4'hd && !ps_r[2]) |->
		next_addr_r == yp_r) else $error("stack top wrong");
endmodule // mns_chk

bind mns_seq mns_chk i_mns_chk (.clk(clk), .rst_n(rst_n), .instr(instr), .direct_in(direct_in),
	.condition_code_n(condition_code_n), .condition_enable_n(condition_enable_n), .carry_in(carry_in),
	.next_addr_r(next_addr_r), .vector_enable_n(vector_enable_n));

// *** dv/mns_seq_bench.sv ***
/* Self-checking bench for the next-address sequencer.
   Assumes mns_src feeds the pins; a reference model predicts every address. */
`timescale 1ns/1ns
module mns_seq_bench;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [18:0] mw = 19'h70000;
	wire [18:0] pins;
	wire [11:0] next_addr_r;
	wire        vector_enable_n;
	wire        stack_full_r;
	reg         ef_r;
	reg  [11:0] stk_r [0:7];
	reg  [11:0] pc_r, cnt_r, ey_r, d, y;
	reg  [17:0] s1_r, s2_r;
	reg  [3:0]  sp_r, o;
	reg         f, c;
	integer     n_mismatch = 0;
	integer     n_checks = 0;
	initial forever #25 clk = ~clk;
	mns_src i_mns_src (.clk(clk), .mw(mw), .vector_enable_n(vector_enable_n), .pins(pins));
	mns_seq i_mns_seq (.clk(clk), .rst_n(rst_n), .instr(pins[18:15]), .direct_in(pins[14:3]),
		.condition_code_n(pins[2]), .condition_enable_n(pins[1]), .carry_in(pins[0]),
		.next_addr_r(next_addr_r), .vector_enable_n(vector_enable_n), .stack_full_r(stack_full_r));
	task m_push;
		begin
			if (sp_r < 4'h8) sp_r = sp_r + 4'h1;
			stk_r[sp_r - 4'h1] = pc_r;
		end
	endtask
	task m_pop;
		if (sp_r != 4'h0) sp_r = sp_r - 4'h1;
	endtask
	// Reference model decodes what the pins showed two edges earlier
	always @(posedge clk or negedge rst_n)
		if (!rst_n) begin
			{pc_r, cnt_r, ey_r, sp_r, s1_r, s2_r} = 76'h0;
			ef_r = 1'b0;
		end else begin
			{o, d, f, c} = s2_r;
			ef_r = (sp_r == 4'h8);
			y = pc_r;
			case (o)
			4'h4: begin
				m_push;
				if (!f) cnt_r = d;
			end
			4'h5: begin
				m_push;
				y = f ? cnt_r : d;
			end
			4'h6: if (!f) y = d;
			4'h7: y = f ? cnt_r : d;
			4'h8: if (cnt_r != 12'h000) begin
				y = stk_r[sp_r - 4'h1];
				cnt_r = cnt_r - 12'h001;
			end else m_pop;
			4'h9: if (cnt_r != 12'h000) begin
				y = d;
				cnt_r = cnt_r - 12'h001;
			end
			4'ha: if (!f) begin
				y = stk_r[sp_r - 4'h1];
				m_pop;
			end
			4'hb: if (!f) begin
				y = d;
				m_pop;
			end
			4'hc: cnt_r = d;
			4'hd: if (f) y = stk_r[sp_r - 4'h1]; else m_pop;
			default: ;
			endcase
			ey_r = y;
			pc_r = y + {11'h0, c};
			s2_r = s1_r;
			s1_r = {pins[18:3], ~pins[1] & pins[2], pins[0]};
		end
	task chk(input [11:0] got, input [11:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD %0t output %h, expected %h", $time, got, exp);
			end
		end
	endtask
	always @(negedge clk)
		if (rst_n) begin
			chk(next_addr_r, ey_r);
			chk({11'h000, stack_full_r}, {11'h000, ef_r});
		end
	task st(input [18:0] w);
		begin
			mw <= w;
			@(posedge clk);
		end
	endtask
	task t_stack;
		begin
			st({4'hc, 12'h002, 3'b011});
			st({4'h4, 12'h0aa, 3'b101});
			st({4'hd, 12'h0bb, 3'b101});
			repeat (3) st({4'h8, 12'h0cc, 3'b100});
			st({4'h4, 12'h001, 3'b011});
			st({4'ha, 12'h0dd, 3'b111});
			repeat (5) st(19'h70000);
		end
	endtask
	task t_rpt;
		begin
			st({4'hc, 12'h001, 3'b011});
			repeat (2) st({4'h9, 12'h055, 3'b010});
			st({4'hc, 12'h000, 3'b010});
			st({4'h9, 12'h066, 3'b011});
			repeat (5) st(19'h70000);
		end
	endtask
	task t_all;
		integer op, k;
		begin
			for (op = 4; op < 15; op = op + 1)
				for (k = 0; k < 4; k = k + 1)
					st({op[3:0], op[3:0], k[1:0], 6'h15, k[1:0] ^ 2'b10, op[0]});
			repeat (5) st(19'h70000);
		end
	endtask
	task conclude;
		begin
			if (n_mismatch == 0 && n_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		#20000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_stack;
		t_rpt;
		t_all;
		conclude;
	end
endmodule // mns_seq_bench

// *** dv/mns_src.sv ***
/* Microword source: pipeline register with a vector field on the direct inputs.
   Assumes the bench hands it one packed microword per cycle. */
`timescale 1ns/1ns
module mns_src (
	input  wire        clk,
	input  wire [18:0] mw,
	input  wire        vector_enable_n,
	output wire [18:0] pins
);
	reg [18:0] pl_r = 19'h70000;
	always @(posedge clk)
		pl_r <= mw;
	// Vector field owns the direct inputs while enabled
	assign pins = vector_enable_n ? pl_r : {pl_r[18:15], 12'h3c5, pl_r[2:0]};
endmodule // mns_src

// *** hw/mns_defs.vh ***
/*
 * Constants for the next-address sequencer: widths, instruction codes,
 * address source selects and reset values.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef MNS_DEFS_VH
`define MNS_DEFS_VH

`define MNS_AW         12
`define MNS_IW         4
`define MNS_SP_W       3
`define MNS_DEPTH      8

// Instruction codes handled by this block
`define MNS_OP_PUSH    4'h4
`define MNS_OP_CALLRD  4'h5
`define MNS_OP_JVEC    4'h6
`define MNS_OP_JRD     4'h7
`define MNS_OP_RPTSTK  4'h8
`define MNS_OP_RPTDIR  4'h9
`define MNS_OP_RTN     4'ha
`define MNS_OP_JPOP    4'hb
`define MNS_OP_LOAD_COUNTER_CONTINUE    4'hc
`define MNS_OP_LOOP    4'hd
`define MNS_OP_SEQUENTIAL_NEXT    4'he

// Address source selects
`define MNS_SRC_PC     2'h0
`define MNS_SRC_D      2'h1
`define MNS_SRC_R      2'h2
`define MNS_SRC_STK    2'h3

`define MNS_ZERO_A     12'h000
`define MNS_ONE_A      12'h001
`define MNS_ZERO_SP    3'h0
`define MNS_ONE_SP     3'h1
`define MNS_MAX_SP     3'h7

// Condition/carry synchroniser reset: enable low, condition low, carry low,
// so the first decodes after reset add nothing to the program counter
`define MNS_CSYNC_RST  3'h0

`endif

// *** hw/mns_seq.v ***
/*
 * Next-address sequencer for instruction codes 4 to 14: stack control,
 * register/counter control and next-address select, with the
 * microprogram counter, register/counter and a small return stack.
 * Assumes instruction, direct inputs and condition pins come from
 * another clock domain or pins and are synchronised here; carry-in too.
 */
`timescale 1ns/1ns
`include "mns_defs.vh"

module mns_seq (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire [`MNS_IW-1:0]     instr,
	input  wire [`MNS_AW-1:0]     direct_in,
	input  wire                   condition_code_n,
	input  wire                   condition_enable_n,
	input  wire                   carry_in,
	output reg  [`MNS_AW-1:0]     next_addr_r,
	output reg                    vector_enable_n,
	output reg                    stack_full_r
);

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	reg  [`MNS_AW-1:0]  d_s1_r;
	reg  [`MNS_AW-1:0]  d_s2_r;
	reg  [`MNS_IW-1:0]  i_s1_r;
	reg  [`MNS_IW-1:0]  i_s2_r;
	reg  [2:0]          c_s1_r;
	reg  [2:0]          c_s2_r;

	// Two flops on every pin cost latency from pin to next address;
	// the microcode pipeline must allow for it.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_s1_r <= `MNS_ZERO_A;
			d_s2_r <= `MNS_ZERO_A;
		end else begin
			d_s1_r <= direct_in;
			d_s2_r <= d_s1_r;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			i_s1_r <= `MNS_OP_SEQUENTIAL_NEXT;
			i_s2_r <= `MNS_OP_SEQUENTIAL_NEXT;
		end else begin
			i_s1_r <= instr;
			i_s2_r <= i_s1_r;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c_s1_r <= `MNS_CSYNC_RST;
			c_s2_r <= `MNS_CSYNC_RST;
		end else begin
			c_s1_r <= {condition_enable_n, condition_code_n, carry_in};
			c_s2_r <= c_s1_r;
		end
	end

	wire cen_n = c_s2_r[2];
	wire cc_n  = c_s2_r[1];
	wire ci    = c_s2_r[0];
	wire fail  = ~cen_n & cc_n;
	wire pass  = ~fail;

	// ==========================================================
	// State: microprogram counter, register/counter, stack
	// ==========================================================
	reg  [`MNS_AW-1:0]   pc_r;
	reg  [`MNS_AW-1:0]   cnt_r;
	reg  [`MNS_SP_W-1:0] sp_r;
	reg  [`MNS_AW-1:0]   stk_r [0:`MNS_DEPTH-1];
	wire cnt_zero = (cnt_r == `MNS_ZERO_A);
	wire [`MNS_AW-1:0] tos = stk_r[sp_r];

	// ==========================================================
	// Instruction decode
	// ==========================================================
	reg  [1:0] src;
	reg        push;
	reg        pop;
	reg        load;
	reg        dec;
	reg        vec;

	always @* begin
		src  = `MNS_SRC_PC;
		push = 1'b0;
		pop  = 1'b0;
		load = 1'b0;
		dec  = 1'b0;
		vec  = 1'b0;
		case (i_s2_r)
			`MNS_OP_PUSH: begin
				push = 1'b1;
				load = pass;
			end
			`MNS_OP_CALLRD: begin
				push = 1'b1;
				src  = pass ? `MNS_SRC_D : `MNS_SRC_R;
			end
			`MNS_OP_JVEC: begin
				vec = 1'b1;
				src = pass ? `MNS_SRC_D : `MNS_SRC_PC;
			end
			`MNS_OP_JRD: begin
				src = pass ? `MNS_SRC_D : `MNS_SRC_R;
			end
			`MNS_OP_RPTSTK: begin
				// Zero-count exit after the last pass gives count plus one bodies
				if (cnt_zero) begin
					pop = 1'b1;
				end else begin
					src = `MNS_SRC_STK;
					dec = 1'b1;
				end
			end
			`MNS_OP_RPTDIR: begin
				if (!cnt_zero) begin
					src = `MNS_SRC_D;
					dec = 1'b1;
				end
			end
			`MNS_OP_RTN: begin
				src = pass ? `MNS_SRC_STK : `MNS_SRC_PC;
				pop = pass;
			end
			`MNS_OP_JPOP: begin
				src = pass ? `MNS_SRC_D : `MNS_SRC_PC;
				pop = pass;
			end
			`MNS_OP_LOAD_COUNTER_CONTINUE: begin
				load = 1'b1;
			end
			`MNS_OP_LOOP: begin
				src = pass ? `MNS_SRC_PC : `MNS_SRC_STK;
				pop = pass;
			end
			default: begin
				src = `MNS_SRC_PC;
			end
		endcase
	end

	reg [`MNS_AW-1:0] y;
	always @* begin
		case (src)
			`MNS_SRC_D:   y = d_s2_r;
			`MNS_SRC_R:   y = cnt_r;
			`MNS_SRC_STK: y = tos;
			default:      y = pc_r;
		endcase
	end

	// ==========================================================
	// Next-state logic
	// ==========================================================
	// Push overwrites the top entry when full; the stack does not guard
	// against unbalanced microcode, which must pair calls and returns.
	reg                  valid_r;
	wire                 sp_full  = (sp_r == `MNS_MAX_SP);
	wire                 sp_empty = (sp_r == `MNS_ZERO_SP);
	wire                 do_push  = push;
	wire                 do_pop   = pop & valid_r;
	wire [`MNS_SP_W-1:0] wr_idx   = (valid_r & ~sp_full) ? sp_r + `MNS_ONE_SP : sp_r;

	reg  [`MNS_AW-1:0]   pc_nxt;
	reg  [`MNS_AW-1:0]   cnt_nxt;
	reg  [`MNS_SP_W-1:0] sp_nxt;
	reg                  valid_nxt;
	reg                  full_nxt;

	// Carry in is widened on purpose to the address width
	always @* begin
		pc_nxt = y + {{(`MNS_AW-1){1'b0}}, ci};
	end

	always @* begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = d_s2_r;
		end else if (dec) begin
			cnt_nxt = cnt_r - `MNS_ONE_A;
		end
	end

	always @* begin
		sp_nxt    = sp_r;
		valid_nxt = valid_r;
		if (do_push) begin
			sp_nxt    = wr_idx;
			valid_nxt = 1'b1;
		end else if (do_pop) begin
			if (sp_empty) begin
				// Popping the last entry empties the stack
				valid_nxt = 1'b0;
			end else begin
				sp_nxt = sp_r - `MNS_ONE_SP;
			end
		end
	end

	// Flag shows the stack as it stood before this edge's push or pop
	always @* begin
		full_nxt = valid_r & sp_full;
	end

	// ==========================================================
	// Registers
	// ==========================================================

	genvar g;
	generate
		for (g = 0; g < `MNS_DEPTH; g = g + 1) begin : g_stk
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stk_r[g] <= `MNS_ZERO_A;
				end else if (do_push && wr_idx == g) begin
					stk_r[g] <= pc_r;
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= `MNS_ZERO_A;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= `MNS_ZERO_A;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_r    <= `MNS_ZERO_SP;
			valid_r <= 1'b0;
		end else begin
			sp_r    <= sp_nxt;
			valid_r <= valid_nxt;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			next_addr_r <= `MNS_ZERO_A;
		end else begin
			next_addr_r <= y;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_enable_n <= 1'b1;
		end else begin
			vector_enable_n <= ~vec;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_full_r <= 1'b0;
		end else begin
			stack_full_r <= full_nxt;
		end
	end

endmodule // mns_seq
